// ### hw/tsr_regs.sv
// thermal sensor register bank behind the index and two-byte bus port
`timescale 1ns/1ps
`default_nettype none
module tsr_regs
  import tsr_pkg::*;
(
  // clock and reset
  input  wire  logic            i_sys_clk,
  input  wire  logic            i_sys_rst,
  // byte port from the two-wire front end
  input  wire  tsr_bus_req_type i_bus,
  output logic [7:0]            o_rd_byte,
  output logic                  o_rd_valid,
  // samples from the converter
  input  wire  logic            i_smp_valid,
  input  wire  logic [15:0]     i_smp_temp,
  // converter control
  output logic                  o_shutdown,
  output logic [1:0]            o_res_code,
  // open-drain event pin
  output logic                  o_event_out,
  output logic                  o_event_oe
);

  typedef struct packed {
    tsr_state_type st;
    logic [7:0]    index;
    logic [15:0]   conf;
    logic [15:0]   hi;
    logic [15:0]   lo;
    logic [15:0]   crit;
    logic [15:0]   tmo;
    logic [1:0]    res;
    logic [15:0]   temp;
    logic [7:0]    wr_msb;
    logic          rd_lo;
    logic [7:0]    rd_byte;
    logic          rd_valid;
    logic          clr;
  } tsr_main_state_type;

  tsr_main_state_type s_q, s_d;
  tsr_evt_cfg_type    evt_cfg;
  logic               evt_status;
  logic [15:0]        wdata;
  logic [15:0]        rdata;
  logic               lock_any;

  function automatic logic [TEMP_W-1:0] res_mask(input logic [1:0] code);
    unique case (code)
      2'h0: res_mask = MASK_9B;
      2'h1: res_mask = MASK_10B;
      2'h2: res_mask = MASK_11B;
      2'h3: res_mask = MASK_12B;
    endcase
  endfunction : res_mask

  function automatic logic [TEMP_W-1:0] lim(input logic [15:0] r);
    lim = r[TEMP_W-1:0];
  endfunction : lim

  // read path: unmapped indices read as zero
  function automatic logic [15:0] rd_mux(input tsr_main_state_type s,
                                         input logic stat);
    logic [15:0] c;
    c = s.conf;
    c[CB_STAT] = stat;
    c[CB_CLR]  = 1'b0;
    unique case (s.index)
      IDX_FEAT:  rd_mux = FEATURE_FLAGS;
      IDX_CONF:  rd_mux = c;
      IDX_HI:    rd_mux = s.hi;
      IDX_LO:    rd_mux = s.lo;
      IDX_CRIT:  rd_mux = s.crit;
      IDX_TEMP:  rd_mux = s.temp;
      IDX_MAKER: rd_mux = MAKER_CODE;
      IDX_REV:   rd_mux = REV_CODE;
      IDX_TMO:   rd_mux = s.tmo;
      IDX_RES:   rd_mux = {14'h0000, s.res};
      default:   rd_mux = 16'h0000;
    endcase
  endfunction : rd_mux

  assign lock_any = s_q.conf[CB_ALOCK] | s_q.conf[CB_CLOCK];
  assign wdata    = {s_q.wr_msb, i_bus.wr_byte};
  assign rdata    = rd_mux(s_q, evt_status);

  always_comb begin
    evt_cfg.mode      = s_q.conf[CB_MODE];
    evt_cfg.pol       = s_q.conf[CB_POL];
    evt_cfg.crit_only = s_q.conf[CB_CRIT];
    evt_cfg.enable    = s_q.conf[CB_EN];
    evt_cfg.shutdown  = s_q.conf[CB_SHDN];
  end

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.clr = 1'b0;
    // the reading follows the selected resolution and carries trip flags
    if (i_smp_valid && !s_q.conf[CB_SHDN]) begin
      s_d.temp = {evt_flags_next(i_smp_temp[TEMP_W-1:0]),
                  i_smp_temp[TEMP_W-1:0] & res_mask(s_q.res)};
    end
    if (i_bus.frame_start) begin
      s_d.rd_lo = 1'b0;
      s_d.st = i_bus.frame_rd ? ST_IDLE : ST_WIDX;
    end else if (i_bus.wr_valid) begin
      unique case (s_q.st)
        ST_WIDX: begin
          s_d.index = i_bus.wr_byte;
          s_d.st = ST_WMSB;
        end
        ST_WMSB: begin
          s_d.wr_msb = i_bus.wr_byte;
          s_d.st = ST_WLSB;
        end
        ST_WLSB: begin
          // third data byte onward is dropped
          s_d.st = ST_IDLE;
          unique case (s_q.index)
            IDX_CONF: begin
              s_d.conf[CB_HYS_HI:CB_HYS_LO] =
                wdata[CB_HYS_HI:CB_HYS_LO];
              if (!lock_any) begin
                s_d.conf[CB_MODE] = wdata[CB_MODE];
                s_d.conf[CB_POL]  = wdata[CB_POL];
                s_d.conf[CB_EN]   = wdata[CB_EN];
              end
              if (!s_q.conf[CB_ALOCK]) begin
                s_d.conf[CB_CRIT] = wdata[CB_CRIT];
              end
              // locks only fall at reset
              s_d.conf[CB_ALOCK] = s_q.conf[CB_ALOCK] | wdata[CB_ALOCK];
              s_d.conf[CB_CLOCK] = s_q.conf[CB_CLOCK] | wdata[CB_CLOCK];
              if (!lock_any || !wdata[CB_SHDN]) begin
                s_d.conf[CB_SHDN] = wdata[CB_SHDN];
              end
              s_d.clr = wdata[CB_CLR] && s_q.conf[CB_MODE];
            end
            IDX_HI: begin
              if (!s_q.conf[CB_ALOCK]) begin
                s_d.hi = wdata;
              end
            end
            IDX_LO: begin
              if (!s_q.conf[CB_ALOCK]) begin
                s_d.lo = wdata;
              end
            end
            IDX_CRIT: begin
              if (!s_q.conf[CB_CLOCK]) begin
                s_d.crit = wdata;
              end
            end
            IDX_TMO: s_d.tmo = wdata;
            IDX_RES: s_d.res = wdata[1:0];
            default: s_d.st = ST_IDLE;
          endcase
        end
        ST_IDLE: s_d.st = ST_IDLE;
      endcase
    end
    if (i_bus.rd_req && !i_bus.frame_start) begin
      s_d.rd_byte  = s_q.rd_lo ? rdata[7:0] : rdata[15:8];
      s_d.rd_valid = 1'b1;
      s_d.rd_lo    = !s_q.rd_lo;
    end
  end

  // trip flags as seen against the sample about to be stored
  function automatic logic [2:0] evt_flags_next(
      input logic [TEMP_W-1:0] t);
    evt_flags_next[2] = $signed(t) > $signed(lim(s_q.crit));
    evt_flags_next[1] = $signed(t) > $signed(lim(s_q.hi));
    evt_flags_next[0] = $signed(t) < $signed(lim(s_q.lo));
  endfunction : evt_flags_next

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q.st       <= ST_IDLE;
      s_q.index    <= IDX_RST;
      s_q.conf     <= CONF_RST;
      s_q.hi       <= LIM_RST;
      s_q.lo       <= LIM_RST;
      s_q.crit     <= LIM_RST;
      s_q.tmo      <= TMO_RST;
      s_q.res      <= RES_RST;
      s_q.temp     <= 16'h0000;
      s_q.wr_msb   <= 8'h00;
      s_q.rd_lo    <= 1'b0;
      s_q.rd_byte  <= 8'h00;
      s_q.rd_valid <= 1'b0;
      s_q.clr      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  tsr_event u_event (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_cfg       (evt_cfg),
    .i_hi        (lim(s_q.hi)),
    .i_lo        (lim(s_q.lo)),
    .i_crit      (lim(s_q.crit)),
    .i_clear     (s_q.clr),
    .i_smp_valid (i_smp_valid),
    .i_temp      (i_smp_temp[TEMP_W-1:0]),
    .o_status    (evt_status),
    .o_flags     (),
    .o_event_out (o_event_out),
    .o_event_oe  (o_event_oe)
  );

  assign o_rd_byte  = s_q.rd_byte;
  assign o_rd_valid = s_q.rd_valid;
  assign o_shutdown = s_q.conf[CB_SHDN];
  assign o_res_code = s_q.res;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_index_take: assert property (
    s_q.st == ST_WIDX && i_bus.wr_valid
    && !i_bus.frame_start |=> s_q.index == $past(i_bus.wr_byte))
    else $error("index byte not taken");
  a_feat_value: assert property (
    s_q.index == IDX_FEAT && i_bus.rd_req
    && !i_bus.frame_start |=> o_rd_valid
    && o_rd_byte == ($past(s_q.rd_lo) ? 8'h0f : 8'h00))
    else $error("feature flags read wrong");
  a_alarm_lock: assert property (
    s_q.conf[CB_ALOCK]
    |=> $stable(s_q.hi) && $stable(s_q.lo))
    else $error("alarm limit changed while locked");
  a_lock_sticky: assert property (
    $past(s_q.conf[CB_ALOCK])
    |-> s_q.conf[CB_ALOCK])
    else $error("alarm lock fell without reset");
  a_clear_reads0: assert property (
    s_q.index == IDX_CONF && i_bus.rd_req
    && s_q.rd_lo && !i_bus.frame_start |=> !o_rd_byte[CB_CLR])
    else $error("clear bit read as one");
  a_shdn_locked: assert property (
    $rose(s_q.conf[CB_SHDN])
    |-> !$past(lock_any))
    else $error("shutdown set under lock");
  a_ro_unchanged: assert property (
    s_q.st == ST_WLSB && i_bus.wr_valid
    && s_q.index == IDX_TEMP && !i_smp_valid |=> $stable(s_q.temp))
    else $error("read-only reading was written");
  a_two_bytes: assert property (
    s_q.st == ST_WMSB && i_bus.wr_valid
    && !i_bus.frame_start |=> s_q.st == ST_WLSB ##0
    s_q.wr_msb == $past(i_bus.wr_byte))
    else $error("data byte pairing lost");

endmodule : tsr_regs
`default_nettype wire

// ### common/tsr_pkg.sv
// package: register map, fields and types of the thermal sensor bank
package tsr_pkg;

  // register indices
  localparam logic [7:0] IDX_FEAT  = 8'h00;
  localparam logic [7:0] IDX_CONF  = 8'h01;
  localparam logic [7:0] IDX_HI    = 8'h02;
  localparam logic [7:0] IDX_LO    = 8'h03;
  localparam logic [7:0] IDX_CRIT  = 8'h04;
  localparam logic [7:0] IDX_TEMP  = 8'h05;
  localparam logic [7:0] IDX_MAKER = 8'h06;
  localparam logic [7:0] IDX_REV   = 8'h07;
  localparam logic [7:0] IDX_TMO   = 8'h08;
  localparam logic [7:0] IDX_RES   = 8'h09;

  // reset values
  localparam logic [15:0] CONF_RST = 16'h0000;
  localparam logic [15:0] LIM_RST  = 16'h0000;
  localparam logic [15:0] TMO_RST  = 16'h0000;
  localparam logic [1:0]  RES_RST  = 2'h1;
  localparam logic [7:0]  IDX_RST  = 8'h00;

  // identity codes: arbitrary neutral values
  localparam logic [15:0] MAKER_CODE = 16'h5a5a;
  localparam logic [15:0] REV_CODE   = 16'h0a01;

  // feature flag fields
  localparam logic       FF_TRIPS   = 1'b1;
  localparam logic       FF_ACCURACY = 1'b1;
  localparam logic       FF_RANGE   = 1'b1;
  localparam logic [1:0] FF_RES     = 2'h1;
  localparam logic       FF_UNUSED  = 1'b0;
  localparam logic       timeout_range_flag = 1'b0;
  localparam logic       alert_shutdown_behaviour = 1'b0;
  localparam logic [7:0] FF_RSVD    = 8'h00;
  localparam logic [15:0] FEATURE_FLAGS = {FF_RSVD,
    alert_shutdown_behaviour, timeout_range_flag, FF_UNUSED, FF_RES,
    FF_RANGE, FF_ACCURACY, FF_TRIPS};

  // control register bit positions
  localparam int CB_MODE  = 0;
  localparam int CB_POL   = 1;
  localparam int CB_CRIT  = 2;
  localparam int CB_EN    = 3;
  localparam int CB_STAT  = 4;
  localparam int CB_CLR   = 5;
  localparam int CB_ALOCK = 6;
  localparam int CB_CLOCK = 7;
  localparam int CB_SHDN  = 8;
  localparam int CB_HYS_LO = 9;
  localparam int CB_HYS_HI = 10;

  // reading fields
  localparam int TEMP_W = 13;
  localparam logic [TEMP_W-1:0] MASK_9B  = 13'h1ff8;
  localparam logic [TEMP_W-1:0] MASK_10B = 13'h1ffc;
  localparam logic [TEMP_W-1:0] MASK_11B = 13'h1ffe;
  localparam logic [TEMP_W-1:0] MASK_12B = 13'h1fff;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WIDX = 4'h2,
    ST_WMSB = 4'h4,
    ST_WLSB = 4'h8
  } tsr_state_type;

  typedef struct packed {
    logic       frame_start;
    logic       frame_rd;
    logic       wr_valid;
    logic [7:0] wr_byte;
    logic       rd_req;
  } tsr_bus_req_type;

  typedef struct packed {
    logic mode;
    logic pol;
    logic crit_only;
    logic enable;
    logic shutdown;
  } tsr_evt_cfg_type;

endpackage : tsr_pkg

// ### hw/tsr_event.sv
// event block: limit compare, event status and open-drain event pin
`timescale 1ns/1ps
`default_nettype none
module tsr_event
  import tsr_pkg::*;
(
  // clock and reset
  input  wire  logic              i_sys_clk,
  input  wire  logic              i_sys_rst,
  // settings
  input  wire  tsr_evt_cfg_type   i_cfg,
  input  wire  logic [TEMP_W-1:0] i_hi,
  input  wire  logic [TEMP_W-1:0] i_lo,
  input  wire  logic [TEMP_W-1:0] i_crit,
  input  wire  logic              i_clear,
  // samples
  input  wire  logic              i_smp_valid,
  input  wire  logic [TEMP_W-1:0] i_temp,
  // results
  output logic                    o_status,
  output logic [2:0]              o_flags,
  output logic                    o_event_out,
  output logic                    o_event_oe
);

  typedef struct packed {
    logic       status;
    logic [2:0] flags;
    logic       cond;
    logic       released;
    logic       shdn;
    logic       oe;
  } tsr_evt_state_type;

  tsr_evt_state_type s_q, s_d;
  logic [2:0] cmp;
  logic       cond;

  always_comb begin
    cmp[2] = $signed(i_temp) > $signed(i_crit);
    cmp[1] = $signed(i_temp) > $signed(i_hi);
    cmp[0] = $signed(i_temp) < $signed(i_lo);
    cond = i_cfg.crit_only ? cmp[2] : |cmp;
    s_d = s_q;
    s_d.shdn = i_cfg.shutdown;
    // no samples are taken while shut down; only a clear with the mode bit set can still drop the status
    if (i_smp_valid && !i_cfg.shutdown) begin
      s_d.flags = cmp;
      s_d.cond = cond;
      s_d.released = 1'b0;
      if (!i_cfg.mode) begin
        s_d.status = cond;
      end else if (cond && !s_q.cond) begin
        s_d.status = 1'b1;
      end
    end else if (i_clear && i_cfg.mode) begin
      s_d.status = 1'b0;
    end
    if (i_cfg.shutdown && !s_q.shdn && alert_shutdown_behaviour) begin
      s_d.released = 1'b1;
    end
    // comparator mode may leave the released state at once
    if (!i_cfg.shutdown && !i_cfg.mode) begin
      s_d.released = 1'b0;
    end
    s_d.oe = i_cfg.enable && !s_d.released && (s_d.status ^ i_cfg.pol);
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_status    = s_q.status;
  assign o_flags     = s_q.flags;
  assign o_event_out = 1'b0;
  assign o_event_oe  = s_q.oe;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_shdn_freeze: assert property (
    i_cfg.shutdown && $past(i_cfg.shutdown)
    && !alert_shutdown_behaviour |-> $stable(s_q.status))
    else $error("event status moved during shutdown");
  a_comp_clear: assert property (
    !i_cfg.mode && i_clear && !i_smp_valid
    && !i_cfg.shutdown |=> s_q.status == $past(s_q.status))
    else $error("clear acted in comparator mode");
  a_disabled_pin: assert property (
    !$past(i_cfg.enable) |-> !o_event_oe)
    else $error("event pin driven while disabled");

endmodule : tsr_event
`default_nettype wire

// ### tb/tsr_master.sv
// bus master model driving the byte port of the register bank
`timescale 1ns/1ps
`default_nettype none
module tsr_master
  import tsr_pkg::*;
(
  // clock
  input  wire logic       i_sys_clk,
  // byte port
  output tsr_bus_req_type o_bus
);
  logic [7:0] last_byte;

  initial begin
    o_bus = '0;
    last_byte = 8'h00;
  end

  // one request per edge; an idle byte lane shows the inverse of the
  // last byte so a stale value is never mistaken for fresh data
  task automatic put(input logic fs, rd, wv, rq, input logic [7:0] b);
    @(posedge i_sys_clk);
    o_bus <= '{frame_start: fs, frame_rd: rd, wr_valid: wv,
               wr_byte: wv ? b : ~last_byte, rd_req: rq};
    if (wv) last_byte = b;
  endtask : put

  // index byte, then msb and lsb; n above 2 sends a stray extra byte
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                    input int n);
    put(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    put(1'b0, 1'b0, 1'b1, 1'b0, idx);
    if (n > 0) put(1'b0, 1'b0, 1'b1, 1'b0, d[15:8]);
    if (n > 1) put(1'b0, 1'b0, 1'b1, 1'b0, d[7:0]);
    if (n > 2) put(1'b0, 1'b0, 1'b1, 1'b0, d[15:8]);
    put(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
  endtask : wr

  // read frame with n back-to-back byte requests
  task automatic rd(input int n);
    put(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    repeat (n) put(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
  endtask : rd
endmodule : tsr_master
`default_nettype wire

// ### tb/tsr_regs_test.sv
// self-checking bench for the thermal sensor register bank
`timescale 1ns/1ps
`default_nettype none
module tsr_regs_test
  import tsr_pkg::*;
;
  logic            i_sys_clk   = 1'b0;
  logic            i_sys_rst   = 1'b1;
  logic            i_smp_valid = 1'b0;
  logic [15:0]     i_smp_temp  = 16'h0000;
  tsr_bus_req_type bus;
  logic [7:0]      rd_byte;
  logic            rd_valid;
  logic            shutdown;
  logic            ev_out;
  logic            ev_oe;
  logic [1:0]      res_code;
  logic [7:0]      exp_q[$];
  int              n_fail     = 0;
  int              num_checks = 0;
  logic [15:0]     lf = 16'h002a;
  logic [15:0]     hi, lo, crit, tr;
  logic [1:0]      res;
  logic [7:0]      ro[5] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h05};

  always #50 i_sys_clk = ~i_sys_clk;

  tsr_master u_mst (.i_sys_clk(i_sys_clk), .o_bus(bus));

  tsr_regs u_dut (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_bus      (bus),
    .o_rd_byte  (rd_byte),
    .o_rd_valid (rd_valid),
    .i_smp_valid(i_smp_valid),
    .i_smp_temp (i_smp_temp),
    .o_shutdown (shutdown),
    .o_res_code (res_code),
    .o_event_out(ev_out),
    .o_event_oe (ev_oe)
  );

  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the valid pulse stands one cycle, so the edge after it still sees it
  always @(posedge i_sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) chk(rd_byte, exp_q.pop_front());
      else chk(16'h0001, 16'h0000);
    end
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  function automatic logic [15:0] rv(input logic [7:0] idx);
    case (idx)
      8'h00:   return 16'h000f;
      8'h06:   return MAKER_CODE;
      8'h07:   return REV_CODE;
      8'h09:   return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction : rv

  // flags compare the full sample; only the stored value is masked
  function automatic logic [15:0] rdg(input logic [15:0] t);
    logic signed [12:0] v;
    logic signed [12:0] u;
    u = t[12:0];
    v = u & (13'h1fff << (2'd3 - res));
    return {u > $signed(crit[12:0]), u > $signed(hi[12:0]),
            u < $signed(lo[12:0]), v};
  endfunction : rdg

  task automatic rst();
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    hi = 16'h0000;
    lo = 16'h0000;
    crit = 16'h0000;
    res = 2'd1;
  endtask : rst

  task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
    u_mst.wr(idx, d, 2);
    repeat (2) @(posedge i_sys_clk);
  endtask : wreg

  task automatic rdreg(input logic [7:0] idx, input logic [15:0] e,
                       input logic setidx);
    if (setidx) u_mst.wr(idx, 16'h0000, 0);
    exp_q.push_back(e[15:8]);
    exp_q.push_back(e[7:0]);
    u_mst.rd(2);
    repeat (2) @(posedge i_sys_clk);
  endtask : rdreg

  task automatic smp(input logic [15:0] t);
    @(posedge i_sys_clk);
    i_smp_valid <= 1'b1;
    i_smp_temp <= t;
    @(posedge i_sys_clk);
    i_smp_valid <= 1'b0;
    i_smp_temp <= ~t;
    repeat (3) @(posedge i_sys_clk);
  endtask : smp

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #5000000;
    n_fail++;
    end_of_test();
  end

  initial begin
    rst();
    for (int i = 0; i < 11; i++) begin
      rdreg(i[7:0], rv(i[7:0]), 1'b1);
    end
    rdreg(IDX_FEAT, 16'h000f, 1'b1);
    rdreg(IDX_FEAT, 16'h000f, 1'b0);
    chk(ev_out, 1'b0);
    foreach (ro[k]) begin
      lf = nxt(lf);
      wreg(ro[k], lf);
      rdreg(ro[k], rv(ro[k]), 1'b1);
    end
    // a stray third data byte must not disturb the stored value
    for (int i = 2; i < 9; i++) begin
      if (i > 4 && i < 8) continue;
      lf = nxt(lf);
      u_mst.wr(i[7:0], lf, 3);
      rdreg(i[7:0], lf, 1'b1);
      rdreg(i[7:0], lf, 1'b0);
    end
    hi = 16'h0190;
    lo = 16'h0050;
    crit = 16'h0550;
    wreg(IDX_HI, hi);
    wreg(IDX_LO, lo);
    wreg(IDX_CRIT, crit);
    for (int c = 0; c < 4; c++) begin
      res = c[1:0];
      wreg(IDX_RES, {14'h0000, res});
      chk(res_code, res);
      repeat (2) begin
        lf = nxt(lf);
        tr = {3'b000, lf[12:0]};
        smp(tr);
        rdreg(IDX_TEMP, rdg(tr), 1'b1);
      end
    end
    smp(16'h0100);
    wreg(IDX_CONF, 16'h0008);
    smp(16'h0200);
    chk(ev_oe, 1'b1);
    smp(16'h0100);
    chk(ev_oe, 1'b0);
    wreg(IDX_CONF, 16'h000a);
    chk(ev_oe, 1'b1);
    wreg(IDX_CONF, 16'h0009);
    smp(16'h0200);
    smp(16'h0100);
    rdreg(IDX_CONF, 16'h0019, 1'b1);
    wreg(IDX_CONF, 16'h0029);
    rdreg(IDX_CONF, 16'h0009, 1'b1);
    smp(16'h0200);
    wreg(IDX_CONF, 16'h0009);
    wreg(IDX_CONF, 16'h0028);
    rdreg(IDX_CONF, 16'h0018, 1'b1);
    wreg(IDX_CONF, 16'h000c);
    smp(16'h0200);
    chk(ev_oe, 1'b0);
    smp(16'h0600);
    chk(ev_oe, 1'b1);
    rdreg(IDX_TEMP, rdg(16'h0600), 1'b1);
    smp(16'h0100);
    // samples taken while shut down are dropped
    wreg(IDX_CONF, 16'h0100);
    chk(shutdown, 1'b1);
    smp(16'h0200);
    rdreg(IDX_TEMP, rdg(16'h0100), 1'b1);
    wreg(IDX_CONF, 16'h0000);
    chk(shutdown, 1'b0);
    wreg(IDX_CONF, 16'h0040);
    wreg(IDX_HI, 16'h0033);
    wreg(IDX_LO, 16'h0011);
    crit = 16'h0444;
    wreg(IDX_CRIT, crit);
    rdreg(IDX_HI, hi, 1'b1);
    rdreg(IDX_LO, lo, 1'b1);
    rdreg(IDX_CRIT, crit, 1'b1);
    wreg(IDX_CONF, 16'h07c0);
    chk(shutdown, 1'b0);
    wreg(IDX_CRIT, 16'h0222);
    rdreg(IDX_CRIT, crit, 1'b1);
    rdreg(IDX_CONF, 16'h06c0, 1'b1);
    rst();
    rdreg(IDX_CONF, 16'h0000, 1'b1);
    end_of_test();
  end
endmodule : tsr_regs_test
`default_nettype wire
